// [dmc_car_model.sv]
// Behavioural model of the vehicle sensors and actuator detect lines
`timescale 1ns/1ps
`default_nettype none
module dmc_car_model (
  input  wire logic [2:0] sense_bad,
  input  wire logic       mclk,
  input  wire logic [2:0] motion,
  input  wire logic [7:0] speed_set,
  input  wire logic [1:0] act_bad,
  output logic            vert_ok,
  output logic            lat_ok,
  output logic            axle_ok,
  output logic [2:0]      act_w,
  output logic [7:0]      speed,
  output logic            front_supply_bad,
  output logic            rear_detect_bad
);
  // Digitized flags and speed change only just after a clock edge
  always_ff @(posedge mclk) begin
    vert_ok          <= !sense_bad[0];
    lat_ok           <= !sense_bad[1];
    axle_ok          <= !sense_bad[2];
    act_w            <= motion;
    speed            <= speed_set;
    front_supply_bad <= act_bad[0];
    rear_detect_bad  <= act_bad[1];
  end
endmodule
`default_nettype wire

// [dmc_deb_if.sv]
// Interface joining the controller to its debounce filters
`timescale 1ns/1ps
`default_nettype none
interface dmc_deb_if #(parameter int unsigned N = 6);
  logic [N-1:0] bad;
  logic [N-1:0] latch;
  logic [N-1:0] fault;
  logic         tick;
  logic         clr;
  modport ctl (output bad, output latch, output tick, output clr, input fault);
  modport deb (input bad, input latch, input tick, input clr, output fault);
endinterface
`default_nettype wire

// [dmc_debounce.sv]
// Debounce filters setting and clearing fault flags
`timescale 1ns/1ps
`default_nettype none
module dmc_debounce
  import dmc_pkg::*;
#(
  parameter int unsigned N = NFAULT
) (
  input  wire logic mclk,
  input  wire logic reset,
  dmc_deb_if.deb    dif
);
  localparam int unsigned CW = 8;
  initial begin
    if (SNS_TICKS >= (1 << CW) || ACT_TICKS >= (1 << CW)) $error("debounce counter too narrow");
  end
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_ch
      localparam logic [CW-1:0] LIM = (g < 3) ? CW'(SNS_TICKS) : CW'(ACT_TICKS);
      logic [CW-1:0] cnt_r;
      logic          flt_r;
      logic          differ;
      assign differ = (dif.bad[g] != flt_r);
      // Count ticks while input disagrees with flag; restart on interruption
      always_ff @(posedge mclk) begin
        if (reset || dif.clr) begin
          cnt_r <= '0;
          flt_r <= 1'b0;
        end else if (!differ) begin
          cnt_r <= '0;
        end else if (dif.tick) begin
          if (cnt_r + 1'b1 >= LIM) begin
            cnt_r <= '0;
            // Latched channels never clear on their own
            flt_r <= dif.latch[g] ? (flt_r | dif.bad[g]) : dif.bad[g];
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
      end
      assign dif.fault[g] = flt_r;
    end
  endgenerate
endmodule
`default_nettype wire

// [dmc_pkg.sv]
// Constants and types for the damping mode controller
`default_nettype none
package dmc_pkg;
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned TICK_MS      = 10;
  localparam int unsigned TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned INIT_MS      = 3000;
  localparam int unsigned INIT_TICKS   = INIT_MS / TICK_MS;
  localparam int unsigned BLINK_MS     = 500;
  localparam int unsigned BLINK_TICKS  = BLINK_MS / TICK_MS;
  localparam int unsigned SNS_DEB_MS   = 1000;
  localparam int unsigned SNS_TICKS    = SNS_DEB_MS / TICK_MS;
  localparam int unsigned ACT_DEB_MS   = 500;
  localparam int unsigned ACT_TICKS    = ACT_DEB_MS / TICK_MS;
  localparam int unsigned HOLD_MS      = 2000;
  localparam int unsigned HOLD_TICKS   = HOLD_MS / TICK_MS;
  localparam logic [7:0]  SPD_HIGH_DEF = 8'h64;
  localparam logic [7:0]  SPD_MID_DEF  = 8'h3C;
  localparam logic [7:0]  SPD_LOW_DEF  = 8'h14;
  // APB register byte offsets
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_FAULT   = 8'h08;
  localparam logic [7:0]  ADDR_SPDTHR  = 8'h0C;
  localparam logic [7:0]  ADDR_HOLD    = 8'h10;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam int unsigned NFAULT       = 6;
  typedef enum logic [1:0] {
    DMC_SOFT   = 2'b00,
    DMC_MEDIUM = 2'b01,
    DMC_HARD   = 2'b10
  } dmc_stiff_e;
  typedef enum logic [1:0] {
    DMC_OFF  = 2'b00,
    DMC_INIT = 2'b01,
    DMC_RUN  = 2'b10,
    DMC_STOP = 2'b11
  } dmc_state_e;
endpackage
`default_nettype wire

// [dmc_top.sv]
// Damping mode controller with APB registers
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dmc_top
  import dmc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ignition_switch,
  input  wire logic        sport_mode,
  input  wire logic        brake,
  input  wire logic        vert_ok,
  input  wire logic        lat_ok,
  input  wire logic        axle_ok,
  input  wire logic        vert_active,
  input  wire logic        lat_active,
  input  wire logic        axle_active,
  input  wire logic [7:0]  speed,
  input  wire logic        front_supply_bad,
  input  wire logic        rear_detect_bad,
  input  wire logic        cpu_fault,
  output logic      [1:0]  stiffness,
  output logic             warn_lamp
);
  // Three-stage synchronisers for pin inputs
  localparam int unsigned NS = 11;
  logic [NS-1:0] pin_in;
  logic [NS-1:0] s1_r;
  logic [NS-1:0] s2_r;
  logic [NS-1:0] s3_r;
  logic [NS-1:0] pin_r;
  assign pin_in = {ignition_switch, sport_mode, brake, vert_ok, lat_ok, axle_ok,
                   vert_active, lat_active, axle_active, front_supply_bad, rear_detect_bad};
  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      pin_r <= '0;
    end else begin
      s1_r  <= pin_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      pin_r <= (s2_r & s3_r) | (pin_r & (s2_r | s3_r)); // agree before change
    end
  end
  logic key_on;
  logic sport;
  logic brk;
  logic v_ok;
  logic l_ok;
  logic a_ok;
  logic v_act;
  logic l_act;
  logic a_act;
  logic f_bad;
  logic r_bad;
  assign {key_on, sport, brk, v_ok, l_ok, a_ok, v_act, l_act, a_act, f_bad, r_bad} = pin_r;

  // Speed bus passes three stages; a value is used once the second and third agree
  logic [7:0] spd1_r;
  logic [7:0] spd2_r;
  logic [7:0] spd3_r;
  logic [7:0] spd_r;
  always_ff @(posedge mclk) begin
    if (reset) begin
      spd1_r <= 8'h00;
      spd2_r <= 8'h00;
      spd3_r <= 8'h00;
      spd_r  <= 8'h00;
    end else begin
      spd1_r <= speed;
      spd2_r <= spd1_r;
      spd3_r <= spd2_r;
      if (spd2_r == spd3_r) spd_r <= spd3_r; // no half-settled word reaches the logic
    end
  end

  // Internal malfunction has its own synchroniser
  logic cpu1_r;
  logic cpu2_r;
  logic cpu3_r;
  always_ff @(posedge mclk) begin
    if (reset) begin
      cpu1_r <= 1'b0;
      cpu2_r <= 1'b0;
      cpu3_r <= 1'b0;
    end else begin
      cpu1_r <= cpu_fault;
      cpu2_r <= cpu1_r;
      cpu3_r <= cpu2_r;
    end
  end

  // Periodic tick divider
  localparam int unsigned TW = $clog2(TICK_CYC);
  logic [TW-1:0] div_r;
  logic          tick;
  assign tick = (div_r == TW'(TICK_CYC - 1));
  always_ff @(posedge mclk) begin
    if (reset || tick) div_r <= '0;
    else div_r <= div_r + 1'b1;
  end

  // Ignition edge detection
  logic key_d_r;
  logic key_rise;
  always_ff @(posedge mclk) begin
    if (reset) key_d_r <= 1'b0;
    else key_d_r <= key_on;
  end
  assign key_rise = key_on & ~key_d_r;

  // Registers written by software
  logic [31:0] ctrl_r;
  logic [7:0]  thr_hi_r;
  logic [7:0]  thr_mid_r;
  logic [7:0]  thr_lo_r;
  logic [15:0] hold_r;

  // Fault debounce channels
  dmc_deb_if #(.N(NFAULT)) dif ();
  logic [NFAULT-1:0] fault;
  logic              ecu_fault_r;
  dmc_state_e        st_r;
  dmc_stiff_e        stiff_r;
  assign dif.bad   = {1'b0,
                      r_bad & (st_r != DMC_RUN || stiff_r == DMC_SOFT),
                      f_bad,
                      ~a_ok, ~l_ok, ~v_ok};
  assign dif.latch = 6'b111000;
  assign dif.tick  = tick;
  assign dif.clr   = key_rise;
  dmc_debounce #(.N(NFAULT)) u_deb (
    .mclk  (mclk),
    .reset (reset),
    .dif   (dif)
  );
  // Internal fault only cleared by reset
  always_ff @(posedge mclk) begin
    if (reset) ecu_fault_r <= 1'b0;
    else if (cpu3_r && cpu2_r) ecu_fault_r <= 1'b1;
  end
  assign fault = {ecu_fault_r, dif.fault[4:0]};
  logic any_fault;
  logic hard_stop;
  assign any_fault = |fault;
  assign hard_stop = |fault[5:3];

  // Requests from the control functions
  logic spd_hi;
  logic spd_mid;
  logic spd_lo;
  logic req_ride;
  logic req_bounce;
  logic req_roll;
  logic req_dive;
  logic req_hard;
  logic req_med;
  assign spd_hi     = spd_r >= thr_hi_r;
  assign spd_mid    = spd_r >= thr_mid_r;
  assign spd_lo     = spd_r >= thr_lo_r;
  assign req_ride   = ~fault[0] & ~fault[2] & (v_act | a_act);
  assign req_bounce = ~fault[0] & v_act & spd_mid;
  assign req_roll   = ~fault[1] & l_act & spd_lo;
  assign req_dive   = brk & spd_lo;
  assign req_hard   = req_roll | req_dive | req_bounce | spd_hi;
  assign req_med    = req_ride | spd_mid | sport;

  // Priority pick: hard, then medium, else soft
  dmc_stiff_e target;
  assign target = req_hard ? DMC_HARD : (req_med ? DMC_MEDIUM : DMC_SOFT);

  // Sequencer state and init timer
  logic [15:0] tmr_r;
  logic [15:0] hold_cnt_r;
  dmc_state_e  st_nxt;
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      DMC_OFF:  if (key_rise) st_nxt = DMC_INIT;
      DMC_INIT: if (tick && tmr_r >= 16'(INIT_TICKS - 1)) st_nxt = hard_stop ? DMC_STOP : DMC_RUN;
      DMC_RUN:  if (hard_stop) st_nxt = DMC_STOP;
      DMC_STOP: st_nxt = DMC_STOP;
      default:  st_nxt = DMC_OFF;
    endcase
    if (!key_on) st_nxt = ecu_fault_r ? DMC_STOP : DMC_OFF;
    else if (key_rise && !ecu_fault_r) st_nxt = DMC_INIT;
  end
  always_ff @(posedge mclk) begin
    if (reset) st_r <= DMC_OFF;
    else st_r <= st_nxt;
  end
  always_ff @(posedge mclk) begin
    if (reset || st_nxt != st_r) tmr_r <= '0;
    else if (tick) tmr_r <= tmr_r + 1'b1;
  end

  // Stiffness command with hold in DMC_RUN when leaving hard for medium or soft
  dmc_stiff_e prev_r;
  dmc_stiff_e stiff_nxt;
  always_comb begin
    stiff_nxt = stiff_r;
    case (st_nxt)
      DMC_INIT: stiff_nxt = DMC_HARD;
      DMC_RUN: begin
        if (target == DMC_HARD || stiff_r != DMC_HARD) stiff_nxt = target;
        else if (tick && hold_cnt_r + 1'b1 >= hold_r) stiff_nxt = target;
      end
      DMC_STOP: if (st_r == DMC_RUN && (fault[3] || fault[4])) stiff_nxt = prev_r;
      default: stiff_nxt = stiff_r;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      stiff_r <= DMC_HARD;
      prev_r  <= DMC_HARD;
    end else begin
      stiff_r <= stiff_nxt;
      if (stiff_nxt != stiff_r) prev_r <= stiff_r;
    end
  end
  // Hold counter restarts whenever hard is requested again
  always_ff @(posedge mclk) begin
    if (reset || stiff_r != DMC_HARD || target == DMC_HARD) hold_cnt_r <= '0;
    else if (tick) hold_cnt_r <= hold_cnt_r + 1'b1;
  end
  assign stiffness = stiff_r;

  // Lamp: lit during init, blinks on fault while ignition is on
  logic [7:0] blink_r;
  logic       blink_ph_r;
  always_ff @(posedge mclk) begin
    if (reset || !any_fault) begin
      blink_r    <= '0;
      blink_ph_r <= 1'b1;
    end else if (tick) begin
      if (blink_r >= 8'(BLINK_TICKS - 1)) begin
        blink_r    <= '0;
        blink_ph_r <= ~blink_ph_r;
      end else begin
        blink_r <= blink_r + 1'b1;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) warn_lamp <= 1'b0;
    else if (any_fault && key_on) warn_lamp <= blink_ph_r;
    else warn_lamp <= (st_r == DMC_INIT);
  end

  // APB slave, zero wait states
  logic wr_en;
  logic rd_en;
  logic hit;
  assign pready  = 1'b1;
  assign hit     = paddr == ADDR_CTRL || paddr == ADDR_STATUS || paddr == ADDR_FAULT ||
                   paddr == ADDR_SPDTHR || paddr == ADDR_HOLD;
  assign pslverr = psel & penable & ~hit;
  assign wr_en   = psel & penable & pwrite & hit;
  assign rd_en   = psel & ~penable & ~pwrite;
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_r    <= CTRL_RST;
      thr_hi_r  <= SPD_HIGH_DEF;
      thr_mid_r <= SPD_MID_DEF;
      thr_lo_r  <= SPD_LOW_DEF;
      hold_r    <= 16'(HOLD_TICKS);
    end else if (wr_en) begin
      case (paddr)
        ADDR_CTRL:   ctrl_r <= pwdata;
        ADDR_SPDTHR: {thr_hi_r, thr_mid_r, thr_lo_r} <= pwdata[23:0];
        ADDR_HOLD:   hold_r <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        default:     ctrl_r <= ctrl_r;
      endcase
    end
  end
  // Read data registered in the setup phase
  always_ff @(posedge mclk) begin
    if (reset) prdata <= 32'h0000_0000;
    else if (rd_en) begin
      case (paddr)
        ADDR_CTRL:   prdata <= ctrl_r;
        ADDR_STATUS: prdata <= {24'h000000, sport, key_on, st_r, warn_lamp, 1'b0, stiff_r};
        ADDR_FAULT:  prdata <= {26'h0000000, fault};
        ADDR_SPDTHR: prdata <= {8'h00, thr_hi_r, thr_mid_r, thr_lo_r};
        ADDR_HOLD:   prdata <= {16'h0000, hold_r};
        default:     prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// [dmc_top_props.sv]
// Concurrent checks on the damping mode controller ports
`timescale 1ns/1ps
`default_nettype none
module dmc_top_props
  import dmc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ignition_switch,
  input wire logic        sport_mode,
  input wire logic        brake,
  input wire logic        vert_ok,
  input wire logic        lat_ok,
  input wire logic        axle_ok,
  input wire logic        vert_active,
  input wire logic        lat_active,
  input wire logic        axle_active,
  input wire logic [7:0]  speed,
  input wire logic        front_supply_bad,
  input wire logic        rear_detect_bad,
  input wire logic        cpu_fault,
  input wire logic [1:0]  stiffness,
  input wire logic        warn_lamp
);
  // Access phase and register decode
  wire acc_w = psel && penable;
  wire map_w = paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_FAULT, ADDR_SPDTHR, ADDR_HOLD};
  wire rsetup_w = psel && !penable && !pwrite;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  a_one_of_three: assert property (stiffness != 2'b11)
    else $error("stiffness code outside the three levels");
  a_reset_values: assert property ($past(reset) |-> stiffness == DMC_HARD && !warn_lamp && prdata == 32'h0)
    else $error("wrong state after reset");
  a_init_start: assert property ($rose(ignition_switch) |-> ##[1:8] (warn_lamp && stiffness == DMC_HARD))
    else $error("init did not light lamp with hard level");
  a_init_holds: assert property ($rose(ignition_switch) |-> ##10 (warn_lamp && stiffness == DMC_HARD) [*8])
    else $error("init lamp or hard level dropped early");
  a_sport_no_soft: assert property (sport_mode [*8] |-> stiffness != DMC_SOFT)
    else $error("soft commanded in sport mode");
  a_lamp_idle_off: assert property (!ignition_switch [*8] |-> !warn_lamp)
    else $error("lamp lit with ignition off");
  a_ready_access: assert property (acc_w |-> pready)
    else $error("no ready in access phase");
  a_err_unmapped: assert property (acc_w && !map_w |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_err_mapped: assert property (acc_w && map_w |-> !pslverr)
    else $error("mapped access refused");
  a_rdata_hold: assert property (!rsetup_w |=> $stable(prdata))
    else $error("read data changed without read setup");
endmodule
bind dmc_top dmc_top_props dmc_top_props_inst (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ignition_switch(ignition_switch), .sport_mode(sport_mode), .brake(brake), .vert_ok(vert_ok),
  .lat_ok(lat_ok), .axle_ok(axle_ok), .vert_active(vert_active), .lat_active(lat_active),
  .axle_active(axle_active), .speed(speed), .front_supply_bad(front_supply_bad),
  .rear_detect_bad(rear_detect_bad), .cpu_fault(cpu_fault), .stiffness(stiffness), .warn_lamp(warn_lamp));
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the damping mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dmc_pkg::*;
();
  logic        mclk, reset, psel, penable, pwrite, pready, pslverr, warn_lamp;
  logic        ignition_switch, sport_mode, brake, cpu_fault;
  logic        vert_ok, lat_ok, axle_ok, front_supply_bad, rear_detect_bad;
  logic [7:0]  paddr, speed, speed_set;
  logic [31:0] pwdata, prdata;
  logic [2:0]  act_w, sense_bad, motion;
  logic [1:0]  stiffness, act_bad;
  int          n_checks, n_mismatch;

  dmc_top dmc_top_inst (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ignition_switch(ignition_switch), .sport_mode(sport_mode), .brake(brake), .vert_ok(vert_ok),
    .lat_ok(lat_ok), .axle_ok(axle_ok), .vert_active(act_w[0]), .lat_active(act_w[1]),
    .axle_active(act_w[2]), .speed(speed), .front_supply_bad(front_supply_bad),
    .rear_detect_bad(rear_detect_bad), .cpu_fault(cpu_fault), .stiffness(stiffness), .warn_lamp(warn_lamp));
  dmc_car_model dmc_car_model_inst (.sense_bad(sense_bad), .mclk(mclk), .motion(motion),
    .speed_set(speed_set), .act_bad(act_bad), .vert_ok(vert_ok), .lat_ok(lat_ok), .axle_ok(axle_ok),
    .act_w(act_w), .speed(speed), .front_supply_bad(front_supply_bad), .rear_detect_bad(rear_detect_bad));

  // Clock at 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd, input logic [31:0] exp,
                     input logic exp_err);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      results();
    end else begin
      if (!wr)
        chk(prdata, exp);
      chk({31'h0, pslverr}, {31'h0, exp_err});
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  initial begin
    {reset, psel, penable, pwrite, ignition_switch, sport_mode, brake, cpu_fault} = 8'h80;
    {paddr, pwdata, speed_set, sense_bad, motion, act_bad} = '0;
    n_checks = 0;
    n_mismatch = 0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    // Reset values of every register
    apb(1'b0, ADDR_CTRL, 32'h0, CTRL_RST, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0, 32'h0000_0002, 1'b0);
    apb(1'b0, ADDR_FAULT, 32'h0, 32'h0, 1'b0);
    apb(1'b0, ADDR_SPDTHR, 32'h0, {8'h00, SPD_HIGH_DEF, SPD_MID_DEF, SPD_LOW_DEF}, 1'b0);
    apb(1'b0, ADDR_HOLD, 32'h0, HOLD_TICKS, 1'b0);
    $display("test reset values done");
    // Writable, read-only and unmapped places, one idle cycle apart
    apb(1'b1, ADDR_CTRL, 32'hA5A5_5A5A, 32'h0, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0, 32'hA5A5_5A5A, 1'b0);
    apb(1'b1, ADDR_SPDTHR, 32'h0050_2810, 32'h0, 1'b0);
    apb(1'b0, ADDR_SPDTHR, 32'h0, 32'h0050_2810, 1'b0);
    apb(1'b1, ADDR_HOLD, 32'h0, 32'h0, 1'b0);
    apb(1'b0, ADDR_HOLD, 32'h0, 32'h1, 1'b0);
    apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF, 32'h0, 1'b0);
    apb(1'b0, ADDR_FAULT, 32'h0, 32'h0, 1'b0);
    apb(1'b1, 8'h20, 32'h1234_5678, 32'h0, 1'b1);
    apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
    $display("test register access done");
    // Two ignition cycles, auto then sport, with busy sensors
    for (int i = 0; i < 2; i++) begin
      sport_mode      <= i[0];
      speed_set       <= 8'hC8;
      motion          <= 3'h7;
      brake           <= 1'b1;
      ignition_switch <= 1'b1;
      repeat (16) @(posedge mclk);
      chk({30'h0, stiffness}, {30'h0, DMC_HARD});
      chk({31'h0, warn_lamp}, 32'h1);
      apb(1'b0, ADDR_STATUS, 32'h0, {24'h0, i[0], 7'h5A}, 1'b0);
      ignition_switch <= 1'b0;
      motion          <= 3'h0;
      brake           <= 1'b0;
      repeat (16) @(posedge mclk);
      chk({31'h0, warn_lamp}, 32'h0);
      $display("test ignition cycle %0d done", i);
    end
    // Internal malfunction latches code 06, stops control, blinks only with ignition on
    cpu_fault <= 1'b1;
    repeat (8) @(posedge mclk);
    apb(1'b0, ADDR_FAULT, 32'h0, 32'h0000_0020, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0, 32'h0000_00B2, 1'b0);
    ignition_switch <= 1'b1;
    repeat (16) @(posedge mclk);
    chk({31'h0, warn_lamp}, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0, 32'h0000_00FA, 1'b0);
    // Mid-run reset is the only way out of code 06
    cpu_fault <= 1'b0;
    reset     <= 1'b1;
    repeat (2) @(posedge mclk);
    reset     <= 1'b0;
    apb(1'b0, ADDR_FAULT, 32'h0, 32'h0, 1'b0);
    chk({30'h0, stiffness}, {30'h0, DMC_HARD});
    $display("test internal fault done");
    results();
  end
endmodule
`default_nettype wire
